// [verilog/bc_irq_pkg.sv]
package bc_irq_pkg;

    // ==========================================================
    // register indices; byte address is four times the index
    // ==========================================================
    localparam logic [7:0]  IDX_PENDING    = 8'h07;
    localparam logic [7:0]  IDX_ENABLE     = 8'h10;
    localparam logic [7:0]  IDX_OUT_ENABLE = 8'h14;
    localparam logic [7:0]  IDX_STATUS     = 8'h20;
    localparam logic [7:0]  IDX_CLEAR      = 8'h21;
    localparam logic [7:0]  IDX_IRQ_EN     = 8'h22;
    localparam int          ADDR_SHIFT     = 2;

    // ==========================================================
    // event bit positions, shared by all three registers
    // ==========================================================
    localparam int          BIT_FRAME_TIMER = 15;
    localparam int          BIT_SEL_MSG     = 14;
    localparam int          BIT_QUEUE_WRAP  = 13;
    localparam int          EOM_SEL_BIT     = 4;
    localparam int          REG_W           = 16;
    localparam int          NUM_EVT         = 3;
    localparam int          EVT_LO          = 13;

    // ==========================================================
    // block status register layout
    // ==========================================================
    localparam int          ST_CAPTURED     = 0;
    localparam int          ST_DROPPED      = 1;
    localparam int          ST_LINE_RAISED  = 2;
    localparam int          ST_W            = 3;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [15:0] RST_PENDING     = 16'h0000;
    localparam logic [15:0] RST_ENABLE      = 16'h0000;
    localparam logic [15:0] RST_OUT_ENABLE  = 16'h0000;
    localparam logic [2:0]  RST_STATUS      = 3'h0;
    localparam logic [2:0]  RST_IRQ_EN      = 3'h0;

    typedef enum logic [1:0] {
        LINE_IDLE,
        LINE_ARMED,
        LINE_ASSERTED
    } line_state_t;

endpackage

// [verilog/bc_irq_gate.sv]
// Our own choice: register access over APB.
`timescale 1ns/10ps
module bc_irq_gate #(
    parameter int REG_W = bc_irq_pkg::REG_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             frame_timer_expired,
    input  wire logic             message_complete,
    input  wire logic [15:0]      message_control_word,
    input  wire logic             queue_wrap,
    input  wire logic             other_irq_request,
    output logic                  log_write,
    output logic      [REG_W-1:0] log_event_bits,
    output logic                  controller_summary_pending,
    output logic                  host_irq_n,
    output logic                  block_irq
);

    // ==========================================================
    // registers
    // ==========================================================
    logic [REG_W-1:0]          enable_q;
    logic [REG_W-1:0]          out_enable_q;
    logic [REG_W-1:0]          pending_q;
    logic [REG_W-1:0]          pending_d;
    logic [REG_W-1:0]          snapshot_q;
    logic [bc_irq_pkg::ST_W-1:0] status_q;
    logic [bc_irq_pkg::ST_W-1:0] irq_en_q;
    logic [bc_irq_pkg::ST_W-1:0] status_set;
    logic [bc_irq_pkg::ST_W-1:0] status_clr;
    logic [31:0]               prdata_q;
    logic                      slverr_q;
    logic                      log_write_q;
    logic [REG_W-1:0]          log_bits_q;
    logic                      summary_q;
    logic                      line_q;
    logic                      block_irq_q;
    bc_irq_pkg::line_state_t   line_st_q;

    // ==========================================================
    // event decode
    // ==========================================================
    logic [REG_W-1:0]          raw_evt;
    logic [REG_W-1:0]          live_evt;
    logic [REG_W-1:0]          dropped_evt;
    logic                      any_live;
    logic                      any_high;
    logic                      sel_msg;

    // only flagged messages count as a selected completion
    assign sel_msg = message_complete
        & message_control_word[bc_irq_pkg::EOM_SEL_BIT];

    always_comb
    begin
        raw_evt = '0;
        raw_evt[bc_irq_pkg::BIT_FRAME_TIMER] = frame_timer_expired;
        raw_evt[bc_irq_pkg::BIT_SEL_MSG]     = sel_msg;
        raw_evt[bc_irq_pkg::BIT_QUEUE_WRAP]  = queue_wrap;
    end

    // enable is sampled only at the event itself, never remembered
    assign live_evt    = raw_evt & enable_q;
    assign dropped_evt = raw_evt & ~enable_q;
    assign any_live    = |live_evt;
    assign any_high    = |(live_evt & out_enable_q);

    // ==========================================================
    // apb decode
    // ==========================================================
    logic [9:0]  word_idx;
    logic        setup_ph;
    logic        access_ph;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit;
    logic [31:0] rd_mux;

    assign word_idx  = paddr[11:bc_irq_pkg::ADDR_SHIFT];
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_acc    = access_ph & pwrite;
    assign rd_acc    = access_ph & ~pwrite;

    function automatic logic idx_is(input logic [9:0] w,
                                    input logic [7:0] i);
        idx_is = (w == {2'h0, i});
    endfunction

    always_comb
    begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        if (idx_is(word_idx, bc_irq_pkg::IDX_PENDING))
            rd_mux[REG_W-1:0] = pending_q;
        else if (idx_is(word_idx, bc_irq_pkg::IDX_ENABLE))
            rd_mux[REG_W-1:0] = enable_q;
        else if (idx_is(word_idx, bc_irq_pkg::IDX_OUT_ENABLE))
            rd_mux[REG_W-1:0] = out_enable_q;
        else if (idx_is(word_idx, bc_irq_pkg::IDX_STATUS))
            rd_mux[bc_irq_pkg::ST_W-1:0] = status_q;
        else if (idx_is(word_idx, bc_irq_pkg::IDX_CLEAR))
            rd_mux = 32'h0000_0000;
        else if (idx_is(word_idx, bc_irq_pkg::IDX_IRQ_EN))
            rd_mux[bc_irq_pkg::ST_W-1:0] = irq_en_q;
        else
            hit = 1'b0;
    end

    // zero wait states: data was latched in the setup cycle
    // so pready can stay high with no read path in access
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = slverr_q & access_ph;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q   <= 32'h0000_0000;
            slverr_q   <= 1'b0;
            snapshot_q <= bc_irq_pkg::RST_PENDING;
        end
        else if (setup_ph)
        begin
            prdata_q   <= pwrite ? 32'h0000_0000 : rd_mux;
            slverr_q   <= ~hit;
            snapshot_q <= pending_q;
        end
    end

    // ==========================================================
    // control registers; byte lanes honoured
    // ==========================================================
    logic en_wr;
    logic oe_wr;
    logic ie_wr;
    logic clr_wr;

    assign en_wr  = wr_acc & idx_is(word_idx, bc_irq_pkg::IDX_ENABLE);
    assign oe_wr  = wr_acc & idx_is(word_idx, bc_irq_pkg::IDX_OUT_ENABLE);
    assign ie_wr  = wr_acc & idx_is(word_idx, bc_irq_pkg::IDX_IRQ_EN);
    assign clr_wr = wr_acc & idx_is(word_idx, bc_irq_pkg::IDX_CLEAR)
                  & pstrb[0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enable_q <= bc_irq_pkg::RST_ENABLE;
        else if (en_wr)
        begin
            if (pstrb[0])
                enable_q[7:0] <= pwdata[7:0];
            if (pstrb[1])
                enable_q[15:8] <= pwdata[15:8];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_enable_q <= bc_irq_pkg::RST_OUT_ENABLE;
        else if (oe_wr)
        begin
            if (pstrb[0])
                out_enable_q[7:0] <= pwdata[7:0];
            if (pstrb[1])
                out_enable_q[15:8] <= pwdata[15:8];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_en_q <= bc_irq_pkg::RST_IRQ_EN;
        else if (ie_wr && pstrb[0])
            irq_en_q <= pwdata[bc_irq_pkg::ST_W-1:0];
    end

    // ==========================================================
    // pending capture, read-to-clear
    // ==========================================================
    logic pend_rd;

    assign pend_rd = rd_acc & idx_is(word_idx, bc_irq_pkg::IDX_PENDING);

    // only bits the host actually saw are cleared, so an event
    // landing between setup and access survives the read
    // the snapshot is what the host got back, not live state
    always_comb
    begin
        if (pend_rd)
            pending_d = (pending_q & ~snapshot_q) | live_evt;
        else
            pending_d = pending_q | live_evt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pending_q <= bc_irq_pkg::RST_PENDING;
        else
            pending_q <= pending_d;
    end

    // ==========================================================
    // log entry and summary pulse
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            log_write_q <= 1'b0;
            log_bits_q  <= '0;
        end
        else
        begin
            log_write_q <= any_live;
            if (any_live)
                log_bits_q <= live_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            summary_q <= 1'b0;
        else
            summary_q <= any_live;
    end

    assign log_write                  = log_write_q;
    assign log_event_bits             = log_bits_q;
    assign controller_summary_pending = summary_q;

    // ==========================================================
    // host line sequencing
    // ==========================================================
    // a high-priority event arms the line; it drops at the next
    // message completion. frame timer expiry outside a message
    // waits for the next completion: a known limitation.
    // a pending read only disarms a raised line; an armed one
    // still pulls the line low at the next completion, so the
    // host may see a late line after it has already polled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            line_st_q <= bc_irq_pkg::LINE_IDLE;
        else
        begin
            case (line_st_q)
                bc_irq_pkg::LINE_IDLE:
                    if (any_high && message_complete)
                        line_st_q <= bc_irq_pkg::LINE_ASSERTED;
                    else if (any_high)
                        line_st_q <= bc_irq_pkg::LINE_ARMED;
                bc_irq_pkg::LINE_ARMED:
                    if (message_complete)
                        line_st_q <= bc_irq_pkg::LINE_ASSERTED;
                bc_irq_pkg::LINE_ASSERTED:
                    if (pend_rd && !any_high)
                        line_st_q <= bc_irq_pkg::LINE_IDLE;
                    else if (pend_rd)
                        line_st_q <= bc_irq_pkg::LINE_ARMED;
                default:
                    line_st_q <= bc_irq_pkg::LINE_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            line_q <= 1'b0;
        else
            line_q <= (line_st_q == bc_irq_pkg::LINE_ASSERTED)
                    | other_irq_request;
    end

    assign host_irq_n = ~line_q;

    // ==========================================================
    // block status, clear and enable
    // ==========================================================
    always_comb
    begin
        status_set = '0;
        status_set[bc_irq_pkg::ST_CAPTURED]    = any_live;
        status_set[bc_irq_pkg::ST_DROPPED]     = |dropped_evt;
        status_set[bc_irq_pkg::ST_LINE_RAISED] =
            (line_st_q != bc_irq_pkg::LINE_ASSERTED)
            & ((line_st_q == bc_irq_pkg::LINE_ARMED) | any_high)
            & message_complete;
        status_clr = clr_wr ? pwdata[bc_irq_pkg::ST_W-1:0]
                            : {bc_irq_pkg::ST_W{1'b0}};
    end

    // set beats clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_q <= bc_irq_pkg::RST_STATUS;
        else
            status_q <= (status_q & ~status_clr) | status_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            block_irq_q <= 1'b0;
        else
            block_irq_q <= |(status_q & irq_en_q);
    end

    assign block_irq = block_irq_q;

endmodule

// [verification/bc_irq_gate_chk.sv]
`timescale 1ns/10ps
module bc_irq_gate_chk #(
    parameter int REG_W = 16
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      prdata,
    input wire logic             pslverr,
    input wire logic             frame_timer_expired,
    input wire logic             message_complete,
    input wire logic [15:0]      message_control_word,
    input wire logic             queue_wrap,
    input wire logic             other_irq_request,
    input wire logic             log_write,
    input wire logic [REG_W-1:0] log_event_bits,
    input wire logic             controller_summary_pending,
    input wire logic             host_irq_n
);
    // ==========================================================
    // event decode and address map
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] raw;
    logic       mapped;
    assign raw = {frame_timer_expired,
                  message_complete & message_control_word[4], queue_wrap};
    assign mapped = paddr[11:2] inside {10'h007, 10'h010, 10'h014,
                                        10'h020, 10'h021, 10'h022};
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_read;
        s_access ##0 !pwrite;
    endsequence
    // ==========================================================
    // assertions
    // ==========================================================
    a_summary_pair: assert property (
        log_write == controller_summary_pending
    ) else $error("summary pulse and log write differ");
    a_log_cause: assert property (
        log_write |-> $past(raw) != 3'h0
    ) else $error("log write without an event");
    a_log_bits: assert property (
        log_write |-> (log_event_bits[15:13] & ~$past(raw)) == 3'h0
    ) else $error("log bit without its event");
    a_log_low_bits: assert property (
        log_write |-> log_event_bits[12:0] == 13'h0
    ) else $error("log bit outside the event field");
    a_unmapped_err: assert property (
        s_access ##0 !mapped |-> pslverr && (pwrite || prdata == 32'h0)
    ) else $error("unmapped access not refused");
    a_mapped_ok: assert property (
        s_access ##0 mapped |-> !pslverr
    ) else $error("mapped access refused");
    a_read_upper: assert property (
        s_read |-> prdata[31:16] == 16'h0
    ) else $error("upper read bits not zero");
    a_other_line: assert property (
        other_irq_request |=> !host_irq_n
    ) else $error("shared request did not pull line low");
    a_fall_cause: assert property (
        $fell(host_irq_n) |-> $past(message_complete, 2)
                              || $past(other_irq_request)
    ) else $error("line fell without message completion");
    a_rise_quiet: assert property (
        $rose(host_irq_n) |-> !$past(other_irq_request)
    ) else $error("line released while shared request high");
endmodule

bind bc_irq_gate bc_irq_gate_chk #(.REG_W(REG_W)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .frame_timer_expired(frame_timer_expired),
    .message_complete(message_complete),
    .message_control_word(message_control_word),
    .queue_wrap(queue_wrap), .other_irq_request(other_irq_request),
    .log_write(log_write), .log_event_bits(log_event_bits),
    .controller_summary_pending(controller_summary_pending),
    .host_irq_n(host_irq_n)
);

// [verification/host_model.sv]
`timescale 1ns/10ps
module host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ==========================================================
    // apb transfers
    // ==========================================================
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // stale write data would hide a late sample
        pwdata <= ~wd;
    endtask
    // low priority events raise no line, so they are found by polling
    task automatic poll(output logic [31:0] v);
        logic er;
        xfer(1'b0, bc_irq_pkg::IDX_PENDING, 32'h0, v, er);
    endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d, rnd;
    logic [3:0]  pstrb;
    logic [15:0] message_control_word, log_event_bits;
    logic        frame_timer_expired, message_complete, queue_wrap, e;
    logic        other_irq_request, log_write, host_irq_n, block_irq;
    logic        controller_summary_pending;
    int          fail_count, comparisons, seed;
    int          m_en, m_oen, m_pend, m_st, m_ien, m_arm, m_line;
    int          log_q[$] = {0};

    bc_irq_gate uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_timer_expired(frame_timer_expired),
        .message_complete(message_complete),
        .message_control_word(message_control_word),
        .queue_wrap(queue_wrap), .other_irq_request(other_irq_request),
        .log_write(log_write), .log_event_bits(log_event_bits),
        .controller_summary_pending(controller_summary_pending),
        .host_irq_n(host_irq_n), .block_irq(block_irq)
    );
    host_model host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );
    // ==========================================================
    // checking and model tasks
    // ==========================================================
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] i, input int v);
        host.xfer(1'b1, i, v, d, e);
        case (i)
            bc_irq_pkg::IDX_ENABLE:     m_en = v & 32'hFFFF;
            bc_irq_pkg::IDX_OUT_ENABLE: m_oen = v & 32'hFFFF;
            bc_irq_pkg::IDX_IRQ_EN:     m_ien = v & 32'h7;
            bc_irq_pkg::IDX_CLEAR:      m_st = m_st & ~v;
            default: ;
        endcase
    endtask
    task automatic rdc(input logic [7:0] i, input int x);
        host.xfer(1'b0, i, 32'h0, d, e);
        chk({e, d}, {1'b0, x});
    endtask
    task automatic drain;
        host.poll(d);
        chk({1'b0, d}, {1'b0, m_pend});
        m_pend = 0;
        // a read only disarms a raised line; an armed one survives
        if (m_line)
            m_arm = 0;
        m_line = 0;
    endtask
    task automatic fire(input bit ft, input bit mc, input bit end_of_message_select,
                        input bit qw);
        int r;
        int x;
        r = (ft << 15) | ((mc & end_of_message_select) << 14) | (qw << 13);
        x = r & m_en;
        // the log bits hold the last entry when nothing is enabled
        if (x != 0)
            log_q.push_back(x);
        if (log_q.size() > 1)
            log_q.delete(0);
        @(posedge pclk);
        frame_timer_expired <= ft;
        message_complete <= mc;
        message_control_word <= 16'($random(seed)) & 16'hFFEF | 16'(end_of_message_select) << 4;
        queue_wrap <= qw;
        @(posedge pclk);
        frame_timer_expired <= 1'b0;
        message_complete <= 1'b0;
        queue_wrap <= 1'b0;
        message_control_word <= 16'($random(seed));
        #1;
        chk({31'h0, log_write, controller_summary_pending},
            {31'h0, x != 0, x != 0});
        chk({17'h0, log_event_bits}, {1'b0, log_q[0]});
        chk({32'h0, host_irq_n}, {32'h0, m_line == 0});
        m_pend = m_pend | x;
        m_st = m_st | ((r & ~m_en) != 0 ? 2 : 0) | (x != 0 ? 1 : 0);
        m_arm = m_arm | ((x & m_oen) != 0);
        m_st = m_st | (mc && m_arm && !m_line ? 4 : 0);
        m_line = m_line | (mc && m_arm);
    endtask
    task automatic line_chk;
        repeat (2) @(posedge pclk);
        #1;
        chk({32'h0, host_irq_n}, {32'h0, m_line == 0});
        chk({32'h0, block_irq}, {32'h0, (m_st & m_ien) != 0});
    endtask
    // ==========================================================
    // clock, watchdog and test sequence
    // ==========================================================
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        // whole sequence takes about 400 cycles
        repeat (20000) @(posedge pclk);
        fail_count++;
        tally_and_finish;
    end
    initial
    begin
        seed = 32'h2012;
        {presetn, frame_timer_expired, message_complete, queue_wrap} = 4'h0;
        {other_irq_request, message_control_word} = 17'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(bc_irq_pkg::IDX_PENDING, 0);
        rdc(bc_irq_pkg::IDX_ENABLE, 0);
        rdc(bc_irq_pkg::IDX_OUT_ENABLE, 0);
        rdc(bc_irq_pkg::IDX_STATUS, 0);
        rdc(bc_irq_pkg::IDX_CLEAR, 0);
        rdc(bc_irq_pkg::IDX_IRQ_EN, 0);
        $display("test 1 done");
        host.xfer(1'b0, 8'h30, 32'h0, d, e);
        chk({e, d}, {1'b1, 32'h0});
        wr(bc_irq_pkg::IDX_PENDING, 32'hFFFF);
        rdc(bc_irq_pkg::IDX_PENDING, 0);
        wr(bc_irq_pkg::IDX_ENABLE, 0);
        fire(1, 1, 1, 1);
        wr(bc_irq_pkg::IDX_ENABLE, 32'hE000);
        drain;
        rdc(bc_irq_pkg::IDX_STATUS, m_st);
        $display("test 2 done");
        for (int k = 0; k < 4; k++)
        begin
            fire(k == 0, k % 2 == 1, k == 1, k == 2);
            line_chk;
        end
        drain;
        $display("test 3 done");
        wr(bc_irq_pkg::IDX_OUT_ENABLE, 32'h8000);
        wr(bc_irq_pkg::IDX_IRQ_EN, 7);
        fire(1, 0, 0, 0);
        line_chk;
        fire(0, 1, 0, 0);
        line_chk;
        rdc(bc_irq_pkg::IDX_STATUS, m_st);
        wr(bc_irq_pkg::IDX_IRQ_EN, 0);
        line_chk;
        wr(bc_irq_pkg::IDX_IRQ_EN, 7);
        wr(bc_irq_pkg::IDX_CLEAR, 7);
        drain;
        line_chk;
        $display("test 4 done");
        @(posedge pclk);
        other_irq_request <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk({32'h0, host_irq_n}, 33'h0);
        @(posedge pclk);
        other_irq_request <= 1'b0;
        line_chk;
        $display("test 5 done");
        repeat (12)
        begin
            rnd = $random(seed);
            wr(bc_irq_pkg::IDX_ENABLE, rnd & 32'hE000);
            wr(bc_irq_pkg::IDX_OUT_ENABLE, (rnd >> 16) & 32'hE000);
            rdc(bc_irq_pkg::IDX_ENABLE, m_en);
            fire(rnd[3], rnd[4], rnd[5], rnd[6]);
            line_chk;
            drain;
            wr(bc_irq_pkg::IDX_CLEAR, rnd[10:8]);
            rdc(bc_irq_pkg::IDX_STATUS, m_st);
        end
        $display("test 6 done");
        tally_and_finish;
    end
endmodule
